// [shared/serial_port_params.svh]
// constants of the serial receive port: register offsets, field positions,
// write masks and bit-timing counts; assumes a 3-bit register address
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_TX_CTRL    3'h0
`define OFS_RX_CTRL    3'h1
`define OFS_RX_DATA    3'h2
`define OFS_BAUD_CTRL  3'h3
`define OFS_DIV_HIGH   3'h4
`define OFS_DIV_LOW    3'h5
`define OFS_IRQ_CTRL   3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define TC_CLK_SRC     7
`define TC_NINE_TX     6
`define TC_TX_EN       5
`define TC_SYNC        4
`define TC_BREAK       3
`define TC_HIGH_SPEED  2
`define TC_SHIFT_EMPTY 1
`define RC_PORT_EN     7
`define RC_NINE_RX     6
`define RC_SINGLE_EN   5
`define RC_CONT_EN     4
`define RC_ADDR_EN     3
`define RC_FRAME_ERR   2
`define RC_OVERRUN     1
`define RC_NINTH       0
`define BC_IDLE        6
`define BC_POLARITY    5
`define BC_WIDE        3
`define IC_RX_IE       0
`define IC_RX_FLAG     1

// ----------------------------------------
// masks, reset values and counts
// ----------------------------------------
`define TC_WMASK       8'hfd
`define RC_WMASK       8'hf8
`define BC_WMASK       8'h28
`define BC_RMASK       8'h68
`define BYTE_RESET     8'h00
`define TPB_SLOW       7'h40
`define TPB_MID        7'h10
`define TPB_FAST       7'h04
`define LAST_BIT_8     4'h7
`define LAST_BIT_9     4'h8
`define BREAK_LAST     4'hb
`define FIFO_DEPTH     2'h2

`endif

// [shared/serial_port_pkg.sv]
// types of the serial receive port
// assumes serial_port_params.svh for the constants the logic uses
package serial_port_pkg;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } rx_state_type;

    typedef struct packed {
        logic       frame_err;
        logic       ninth;
        logic [7:0] data;
    } rx_entry_type;

    typedef struct packed {
        rx_entry_type [1:0] mem;
        logic               wptr;
        logic               rptr;
        logic [1:0]         count;
        rx_entry_type       head;
    } fifo_state_type;

    typedef struct packed {
        logic [7:0]   tx_ctrl;
        logic [7:0]   rx_ctrl;
        logic [7:0]   baud_ctrl;
        logic [7:0]   div_hi;
        logic [7:0]   div_lo;
        logic         rie;
        logic         overrun;
        logic         line_prev;
        logic [2:0]   hist;
        logic [15:0]  timer;
        logic [6:0]   tick_cnt;
        logic [3:0]   bit_cnt;
        rx_state_type rx_state;
        logic [8:0]   shift;
        logic         brk_active;
        logic [6:0]   brk_ticks;
        logic [3:0]   brk_bits;
        logic [7:0]   rdata;
    } port_state_type;

endpackage

// [shared/rx_fifo_if.sv]
// link between the receiver and its character store
// assumes serial_port_pkg is compiled first
`timescale 1ns/10ps
interface rx_fifo_if;
    import serial_port_pkg::*;
    logic         push;
    rx_entry_type push_entry;
    logic         pop;
    logic         flush;
    rx_entry_type head;
    logic         empty;
    logic         full;
    modport owner (output push, push_entry, pop, flush, input head, empty, full);
    modport store (input push, push_entry, pop, flush, output head, empty, full);
endinterface

// [verilog/rx_char_fifo.sv]
// two-character receive store with registered head entry
// assumes pushes, pops and flush come from the port logic on ref_clk
`timescale 1ns/10ps
`include "serial_port_params.svh"
module rx_char_fifo (
    input  wire logic ref_clk, // system clock
    input  wire logic rst,     // synchronous reset
    input  wire logic ce,      // clock enable
    rx_fifo_if.store  f        // store side of the link
);
    import serial_port_pkg::*;

    fifo_state_type s_q;
    fifo_state_type s_d;
    logic           do_push;
    logic           do_pop;

    always_comb begin
        s_d     = s_q;
        do_push = f.push && (s_q.count != `FIFO_DEPTH);
        do_pop  = f.pop && (s_q.count != 2'h0);
        if (do_push) begin
            s_d.mem[s_q.wptr] = f.push_entry;
            s_d.wptr          = ~s_q.wptr;
        end
        if (do_pop) begin
            s_d.rptr = ~s_q.rptr;
        end
        s_d.count = s_q.count + {1'b0, do_push} - {1'b0, do_pop};
        if (f.flush) begin
            s_d.wptr  = 1'b0;
            s_d.rptr  = 1'b0;
            s_d.count = 2'h0;
        end
        // head follows the new pointer so a status read right after a pop is current
        s_d.head = s_d.mem[s_d.rptr];
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign f.head  = s_q.head;
    assign f.empty = (s_q.count == 2'h0);
    assign f.full  = (s_q.count == `FIFO_DEPTH);
endmodule

// [verilog/serial_rx_port.sv]
// asynchronous serial receive port with its control, status and baud registers
// assumes register strobes and the receive pin are synchronous to ref_clk
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "serial_port_params.svh"
module serial_rx_port (
    input  wire logic       ref_clk,         // system clock, 250 MHz
    input  wire logic       rst,             // synchronous reset, active high
    input  wire logic       ce,              // clock enable, freezes all state
    input  wire logic [2:0] addr,            // register address
    input  wire logic [7:0] wdata,           // write data
    input  wire logic       wr_stb,          // write strobe
    input  wire logic       rd_stb,          // read strobe
    output wire logic [7:0] rdata,           // read data, cycle after strobe
    input  wire logic       receive_pin,     // serial data in
    output wire logic       transmit_pin,    // serial data out, idle high
    output wire logic       transmit_pin_oe, // transmit pin drive enable
    output wire logic       receive_flag,    // unread character waiting
    output wire logic       rx_irq           // receive interrupt request
);
    import serial_port_pkg::*;

    port_state_type s_q;
    port_state_type s_d;
    rx_fifo_if      fifo_link ();

    logic        port_on;
    logic        sync_mode;
    logic        rx_on;
    logic        nine;
    logic        addr_mode;
    logic        line;
    logic        maj;
    logic        baud_tick;
    logic        div_write;
    logic        decide;
    logic        char_done;
    logic        keep;
    logic        brk_go;
    logic [15:0] divisor;
    logic [6:0]  tpb;
    logic [6:0]  decide_pt;
    logic [6:0]  last_tick;
    logic [3:0]  last_bit;
    logic [7:0]  rd_val;
    rx_entry_type entry;

    rx_char_fifo store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .f       (fifo_link.store)
    );

    // ----------------------------------------
    // mode decode and baud timing
    // ----------------------------------------
    always_comb begin
        port_on   = s_q.rx_ctrl[`RC_PORT_EN];
        sync_mode = s_q.tx_ctrl[`TC_SYNC];
        // overrun holds the receiver idle until it is cleared
        rx_on     = port_on && s_q.rx_ctrl[`RC_CONT_EN] && !sync_mode
                    && !s_q.overrun;
        nine      = s_q.rx_ctrl[`RC_NINE_RX];
        addr_mode = nine && s_q.rx_ctrl[`RC_ADDR_EN];
        line      = receive_pin ^ s_q.baud_ctrl[`BC_POLARITY];
        divisor   = s_q.baud_ctrl[`BC_WIDE] ? {s_q.div_hi, s_q.div_lo}
                                            : {`BYTE_RESET, s_q.div_lo};
        // timer ticks per bit: 64, 16 or 4 timer periods per bit
        if (sync_mode) begin
            tpb = `TPB_FAST;
        end else if (s_q.baud_ctrl[`BC_WIDE]) begin
            tpb = s_q.tx_ctrl[`TC_HIGH_SPEED] ? `TPB_FAST : `TPB_MID;
        end else begin
            tpb = s_q.tx_ctrl[`TC_HIGH_SPEED] ? `TPB_MID : `TPB_SLOW;
        end
        decide_pt = (tpb >> 1) + 7'h01;
        last_tick = tpb - 7'h01;
        last_bit  = nine ? `LAST_BIT_9 : `LAST_BIT_8;
        baud_tick = port_on && (s_q.timer == divisor);
        div_write = wr_stb && ((addr == `OFS_DIV_HIGH) || (addr == `OFS_DIV_LOW));
        decide    = baud_tick && (s_q.tick_cnt == decide_pt);
        // ninth bit and transmit format are stored for the transmit path
        brk_go    = port_on && s_q.tx_ctrl[`TC_TX_EN] && !sync_mode
                    && s_q.tx_ctrl[`TC_BREAK];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d                  = s_q;
        fifo_link.push       = 1'b0;
        fifo_link.pop        = 1'b0;
        fifo_link.flush      = 1'b0;
        char_done            = 1'b0;
        keep                 = 1'b0;
        rd_val               = `BYTE_RESET;
        entry.data           = nine ? s_q.shift[7:0] : s_q.shift[8:1];
        entry.ninth          = nine && s_q.shift[8];
        entry.frame_err      = 1'b0;
        s_d.rdata            = `BYTE_RESET;
        s_d.line_prev        = line;

        // new divider restarts the timer so the new rate applies at once
        if (!port_on || div_write || baud_tick) begin
            s_d.timer = '0;
        end else begin
            s_d.timer = s_q.timer + 16'h0001;
        end

        // samples at each tick; three around bit centre vote
        if (baud_tick) begin
            s_d.hist     = {s_q.hist[1:0], line};
            s_d.tick_cnt = (s_q.tick_cnt == last_tick) ? 7'h00 : s_q.tick_cnt + 7'h01;
        end
        maj = (s_d.hist[0] & s_d.hist[1]) | (s_d.hist[0] & s_d.hist[2])
              | (s_d.hist[1] & s_d.hist[2]);
        entry.frame_err = !maj;

        case (s_q.rx_state)
            RX_IDLE: begin
                if (s_q.line_prev && !line) begin
                    s_d.rx_state = RX_START;
                    s_d.tick_cnt = 7'h00;
                end
            end
            RX_START: begin
                // a glitch that is gone at mid-bit aborts without error
                if (decide) begin
                    s_d.bit_cnt  = 4'h0;
                    s_d.rx_state = maj ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (decide) begin
                    s_d.shift   = {maj, s_q.shift[8:1]};
                    s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    if (s_q.bit_cnt == last_bit) begin
                        s_d.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (decide) begin
                    keep         = !(addr_mode && !entry.ninth);
                    char_done    = rx_on && keep;
                    s_d.rx_state = RX_IDLE;
                end
            end
            default: begin
                s_d.rx_state = RX_IDLE;
            end
        endcase
        if (!rx_on) begin
            s_d.rx_state = RX_IDLE;
        end

        if (char_done) begin
            if (fifo_link.full) begin
                s_d.overrun = 1'b1;
            end else begin
                fifo_link.push = 1'b1;
            end
        end
        if (!s_q.rx_ctrl[`RC_CONT_EN]) begin
            s_d.overrun = 1'b0;
        end

        // break: low line for twelve bit times, then the request bit drops
        if (s_q.brk_active) begin
            if (baud_tick) begin
                if (s_q.brk_ticks == last_tick) begin
                    s_d.brk_ticks = 7'h00;
                    s_d.brk_bits  = s_q.brk_bits + 4'h1;
                    if (s_q.brk_bits == `BREAK_LAST) begin
                        s_d.brk_active         = 1'b0;
                        s_d.tx_ctrl[`TC_BREAK] = 1'b0;
                    end
                end else begin
                    s_d.brk_ticks = s_q.brk_ticks + 7'h01;
                end
            end
        end else if (brk_go) begin
            s_d.brk_active = 1'b1;
            s_d.brk_ticks  = 7'h00;
            s_d.brk_bits   = 4'h0;
        end

        // port disable holds the datapath in reset, registers keep values
        if (!port_on) begin
            fifo_link.flush = 1'b1;
            s_d.rx_state    = RX_IDLE;
            s_d.overrun     = 1'b0;
            s_d.brk_active  = 1'b0;
        end

        // writes come last so software wins over a same-cycle hardware clear
        if (wr_stb) begin
            if (addr == `OFS_TX_CTRL) begin
                s_d.tx_ctrl = wdata & `TC_WMASK;
            end else if (addr == `OFS_RX_CTRL) begin
                s_d.rx_ctrl = wdata & `RC_WMASK;
            end else if (addr == `OFS_BAUD_CTRL) begin
                s_d.baud_ctrl = wdata & `BC_WMASK;
            end else if (addr == `OFS_DIV_HIGH) begin
                s_d.div_hi = wdata;
            end else if (addr == `OFS_DIV_LOW) begin
                s_d.div_lo = wdata;
            end else if (addr == `OFS_IRQ_CTRL) begin
                s_d.rie = wdata[`IC_RX_IE];
            end
        end

        if (rd_stb) begin
            if (addr == `OFS_TX_CTRL) begin
                rd_val                  = s_q.tx_ctrl;
                rd_val[`TC_SHIFT_EMPTY] = !s_q.brk_active;
            end else if (addr == `OFS_RX_CTRL) begin
                rd_val                = s_q.rx_ctrl;
                rd_val[`RC_FRAME_ERR] = !fifo_link.empty && fifo_link.head.frame_err;
                rd_val[`RC_OVERRUN]   = s_q.overrun;
                rd_val[`RC_NINTH]     = !fifo_link.empty && fifo_link.head.ninth;
            end else if (addr == `OFS_RX_DATA) begin
                rd_val        = fifo_link.head.data;
                fifo_link.pop = 1'b1;
            end else if (addr == `OFS_BAUD_CTRL) begin
                rd_val           = s_q.baud_ctrl;
                rd_val[`BC_IDLE] = (s_q.rx_state == RX_IDLE);
            end else if (addr == `OFS_DIV_HIGH) begin
                rd_val = s_q.div_hi;
            end else if (addr == `OFS_DIV_LOW) begin
                rd_val = s_q.div_lo;
            end else if (addr == `OFS_IRQ_CTRL) begin
                rd_val[`IC_RX_IE]   = s_q.rie;
                rd_val[`IC_RX_FLAG] = receive_flag;
            end
            s_d.rdata = rd_val;
        end
    end

    assign fifo_link.push_entry = entry;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata           = s_q.rdata;
    assign transmit_pin    = !s_q.brk_active;
    assign transmit_pin_oe = port_on;
    assign receive_flag    = port_on && !fifo_link.empty;
    assign rx_irq          = receive_flag && s_q.rie;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_rx_held_idle : assert property (
        ce && !rx_on |=> s_q.rx_state == RX_IDLE)
        else $error("receiver left idle while disabled");

    chk_flag_after_push : assert property (
        ce && fifo_link.push && !fifo_link.full && !wr_stb |=> receive_flag)
        else $error("receive flag missing after push");

    chk_overrun_cleared : assert property (
        ce && !s_q.rx_ctrl[`RC_CONT_EN] |=> !s_q.overrun)
        else $error("overrun survived receive disable");

    chk_addr_filter : assert property (
        fifo_link.push && addr_mode |-> fifo_link.push_entry.ninth)
        else $error("data character buffered in address mode");

    chk_data_read : assert property (
        ce && rd_stb && addr == `OFS_RX_DATA && !fifo_link.empty
        |=> rdata == $past(fifo_link.head.data))
        else $error("data read does not return head character");

    chk_shift_status : assert property (
        ce && rd_stb && addr == `OFS_TX_CTRL
        |=> rdata[`TC_SHIFT_EMPTY] == !$past(s_q.brk_active))
        else $error("shift empty status wrong");

    chk_overrun_set : assert property (
        ce && char_done && fifo_link.full |=> s_q.overrun && s_q.rx_state == RX_IDLE)
        else $error("overrun not set on third character");

    chk_frame_flag : assert property (
        fifo_link.push |-> fifo_link.push_entry.frame_err == !maj)
        else $error("framing error does not follow stop sample");

    chk_div_restart : assert property (
        ce && div_write |=> s_q.timer == 16'h0000)
        else $error("divider write did not restart timer");

    chk_reserved_zero : assert property (
        ce && rd_stb && addr == `OFS_BAUD_CTRL |=> (rdata & ~`BC_RMASK) == 8'h00)
        else $error("unimplemented baud bits read nonzero");

    chk_break_self_clear : assert property (
        $fell(s_q.brk_active) && !$past(wr_stb) && $past(port_on)
        |-> !s_q.tx_ctrl[`TC_BREAK])
        else $error("break request not cleared after break");
endmodule

// [dv/serial_line_model.sv]
// behavioural remote transmitter on the shared receive line
// assumes ref_clk comes from the bench; each send call gives its bit length in clocks
`timescale 1ns/10ps
module serial_line_model (
    input  wire logic ref_clk, // system clock
    output logic      line     // shared serial line, idle high unless set_idle inverts it
);
    logic inv_q = 1'b0;
    initial line = 1'b1;
    // idle level follows the chosen polarity, so no false start edge
    task automatic set_idle(input logic inv);
        @(posedge ref_clk);
        inv_q = inv;
        line <= ~inv;
    endtask
    // start, data lsb first, stop, then one idle bit before returning
    task automatic send(input logic [8:0] ch, input int nbits, input logic stop, input int clks);
        logic [11:0] fr;
        int          i;
        fr = 12'hfff;
        fr[0] = 1'b0;
        for (i = 0; i < nbits; i++) begin
            fr[i + 1] = ch[i];
        end
        fr[nbits + 1] = stop;
        for (i = 0; i <= nbits + 2; i++) begin
            @(posedge ref_clk);
            line <= fr[i] ^ inv_q;
            repeat (clks - 1) @(posedge ref_clk);
        end
    endtask
endmodule

// [dv/testbench.sv]
// self-checking bench of the serial receive port with a queue model
// assumes the design's register map and a remote transmitter on the line
`timescale 1ns/10ps
module testbench;
    logic       ref_clk, rst, ce, wr_stb, rd_stb, sync, ie, ovr, rx_on, addr_mode, nine;
    logic [2:0] addr;
    logic [7:0] wdata, rc_val, got;
    wire  logic [7:0] rdata;
    wire  logic line, transmit_pin, transmit_pin_oe, receive_flag, rx_irq;
    logic [9:0] exp_q[$];
    int         num_errors = 0;
    int         tests_run = 0;
    int         i, k;
    logic [7:0] sp_tx[4] = '{8'h00, 8'h04, 8'h00, 8'h04};
    logic [7:0] sp_bc[4] = '{8'h00, 8'h08, 8'h08, 8'h00};
    logic [7:0] sp_lo[4] = '{8'h00, 8'h03, 8'h00, 8'h01};
    int         sp_clk[4] = '{64, 16, 16, 32};

    serial_rx_port u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .receive_pin(line),
        .transmit_pin(transmit_pin), .transmit_pin_oe(transmit_pin_oe),
        .receive_flag(receive_flag), .rx_irq(rx_irq));
    serial_line_model u_line (.ref_clk(ref_clk), .line(line));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // bus cycles and comparisons
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
        // let the registered outputs settle before anyone looks at them
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", name, e, g);
            num_errors++;
        end
    endtask
    task automatic set_rc(input logic [7:0] d);
        wr(3'h1, d);
        rc_val = d & 8'hf8;
        rx_on = d[7] & d[4] & ~sync;
        nine = d[6];
        addr_mode = d[6] & d[3];
        if (!d[4] || !d[7]) ovr = 1'b0;
        if (!d[7]) exp_q.delete();
    endtask
    // model decides from the rules whether the character is kept
    task automatic tx_char(input logic [8:0] ch, input logic stop, input int clks);
        u_line.send(ch, nine ? 9 : 8, stop, clks);
        if (rx_on && !ovr && (!addr_mode || ch[8])) begin
            if (exp_q.size() < 2) exp_q.push_back({~stop, nine & ch[8], ch[7:0]});
            else ovr = 1'b1;
        end
    endtask
    task automatic check_head();
        logic [9:0] e;
        logic       f;
        #1;
        e = (exp_q.size() != 0) ? exp_q[0] : 10'h000;
        f = exp_q.size() != 0;
        chk("receive_flag", {7'h00, f}, {7'h00, receive_flag});
        chk("rx_irq", {7'h00, f & ie}, {7'h00, rx_irq});
        rd(3'h1, got);
        chk("status", rc_val | {5'h00, e[9], ovr, e[8]}, got);
        if (f) begin
            rd(3'h2, got);
            chk("data", e[7:0], got);
            void'(exp_q.pop_front());
        end
    endtask
    task automatic drain();
        while (exp_q.size() != 0) check_head();
        check_head();
    endtask
    task complete_run();
        $display("errors %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        complete_run();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(77728));
        {rst, ce, wr_stb, rd_stb, addr, wdata} = {2'b11, 2'b00, 3'h0, 8'h00};
        {sync, ie, ovr, rx_on, addr_mode, nine, rc_val} = {6'h00, 8'h00};
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (k = 0; k < 8; k++) begin
            rd(3'(k), got);
            chk("reset", (k == 0) ? 8'h02 : 8'h00, got & ((k == 3) ? 8'hbf : 8'hff));
        end
        chk("pin_reset", 8'h01, {6'h00, transmit_pin_oe, transmit_pin});
        wr(3'h0, 8'hf5);
        rd(3'h0, got);
        chk("tx_ctrl", 8'hf7, got);
        wr(3'h3, 8'hff);
        rd(3'h3, got);
        chk("baud_ctrl", 8'h28, got & 8'hbf);
        wr(3'h7, 8'hff);
        rd(3'h7, got);
        chk("unmapped", 8'h00, got);
        wr(3'h0, 8'h04);
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h01);
        ie = 1'b1;
        set_rc(8'h90);
        chk("oe_on", 8'h01, {7'h00, transmit_pin_oe});
        for (i = 0; i < 6; i++) begin
            tx_char({1'b0, 8'($urandom)}, ($urandom % 3) != 0, 16);
            check_head();
        end
        // third and fourth characters arrive with the store full
        for (i = 0; i < 4; i++) tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        drain();
        set_rc(8'h80);
        set_rc(8'h90);
        check_head();
        tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        wr(3'h6, 8'h00);
        ie = 1'b0;
        check_head();
        wr(3'h6, 8'h01);
        ie = 1'b1;
        set_rc(8'hd8);
        // read after each character so the store never overruns here
        for (i = 0; i < 6; i++) begin
            tx_char({1'(i), 8'($urandom)}, 1'b1, 16);
            check_head();
        end
        drain();
        set_rc(8'hd0);
        for (i = 0; i < 4; i++) begin
            tx_char({1'(i), 8'($urandom)}, 1'b1, 16);
            check_head();
        end
        drain();
        set_rc(8'h90);
        for (k = 0; k < 4; k++) begin
            wr(3'h0, sp_tx[k]);
            wr(3'h3, sp_bc[k]);
            wr(3'h5, sp_lo[k]);
            tx_char({1'b0, 8'($urandom)}, 1'b1, sp_clk[k]);
            check_head();
        end
        wr(3'h0, 8'h04);
        wr(3'h5, 8'h00);
        set_rc(8'h80);
        u_line.set_idle(1'b1);
        wr(3'h3, 8'h20);
        set_rc(8'h90);
        tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        check_head();
        set_rc(8'h80);
        wr(3'h3, 8'h00);
        u_line.set_idle(1'b0);
        sync = 1'b1;
        wr(3'h0, 8'h14);
        set_rc(8'h90);
        tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        check_head();
        sync = 1'b0;
        wr(3'h0, 8'h04);
        set_rc(8'h10);
        chk("oe_off", 8'h00, {7'h00, transmit_pin_oe});
        tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        check_head();
        set_rc(8'h80);
        tx_char({1'b0, 8'($urandom)}, 1'b1, 16);
        check_head();
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr(3'h6, 8'h00);
        ce <= 1'b1;
        rd(3'h6, got);
        chk("ce_hold", 8'h01, got);
        set_rc(8'h90);
        wr(3'h0, 8'h2c);
        rd(3'h0, got);
        chk("break_busy", 8'h2c, got);
        chk("break_pin", 8'h00, {7'h00, transmit_pin});
        k = 0;
        while (transmit_pin !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        // twelve bit times of 16 clocks, less the cycles spent reading
        chk("break_len", 8'h01, {7'h00, k > 185 && k < 195});
        rd(3'h0, got);
        chk("break_done", 8'h26, got);
        complete_run();
    end
endmodule
